// File: logic/smdd_top.v
// Front panel monitor, jog, forced output and diagnosis logic
//
// Our own choices: strobed register access and the address map.
`include "smdd_map.vh"
// Operation
// - Codes 0 to 16 select drive quantities
// - Codes 19 to 22 show mapping words
// - Codes 23 to 26 show status words
// - 16-bit: five decimal or four hex
// - 32-bit decimal split low five, high rest
// - 32-bit hex halves marked h or L
// - Decimal negative shows lit points; hex unsigned
// - Monitor values 32-bit, halves and format free
// - Parameters use one fixed format
// - Code 17 reports two resonance frequencies
// - Code 18 index position clamped +-5000
// - Set key shows stored fault code
// - Jog setup shows speed, default 20
// - Jog turns only while key held
// - Jog needs servo on; mode returns
// - 406 forces outputs, 400 restores normal
// - Force value bits drive outputs
// - Force value cleared at power up
// - Forcing works only with servo off
// - Input word bit per input, ascending
// - Output word bit per output, ascending
// - Hex force value blanks fifth digit
// - Power-up shows name then value; keys step
module smdd_top #(
    parameter P_NAME_CYC = `SMDD_NAME_MS * `SMDD_CLK_KHZ
) (
    input wire i_clk,
    input wire i_rst,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    input wire i_key_up,
    input wire i_key_down,
    input wire i_key_set,
    input wire i_key_mode,
    input wire i_servo_on,
    input wire [7:0] i_digital_input,
    input wire [4:0] i_do_normal,
    input wire i_fault_evt,
    input wire [15:0] i_fault_code,
    input wire [31:0] i_quant_data,
    input wire [15:0] i_res1_hz,
    input wire [15:0] i_res2_hz,
    input wire [31:0] i_enc_index_pos,
    output reg [4:0] o_quant_sel,
    output reg [7:0] o_sub_sel,
    output reg [24:0] o_disp_glyph,
    output reg [4:0] o_disp_dp,
    output reg [4:0] o_dout,
    output reg o_jog_fwd,
    output reg o_jog_rev,
    output reg [15:0] o_jog_speed
);
    localparam [6:0] S_NAME = 7'h01;
    localparam [6:0] S_MON = 7'h02;
    localparam [6:0] S_FPAR = 7'h04;
    localparam [6:0] S_FSHOW = 7'h08;
    localparam [6:0] S_JPAR = 7'h10;
    localparam [6:0] S_JSET = 7'h20;
    localparam [6:0] S_JOG = 7'h40;
    localparam [31:0] NAME_END = P_NAME_CYC - 1;
    localparam [23:0] NAME_LAST = NAME_END[23:0];

    reg [6:0] state_r;
    reg [6:0] state_nxt;
    reg [23:0] name_cnt_r;
    reg [3:0] key_s1_r;
    reg [3:0] key_s2_r;
    reg [3:0] key_s3_r;
    reg [7:0] din_s1_r;
    reg [7:0] din_s2_r;
    reg son_s1_r;
    reg son_s2_r;
    reg [4:0] mon_sel_r;
    reg [3:0] disp_ctl_r;
    reg [15:0] special_r;
    reg force_en_r;
    reg [4:0] force_val_r;
    reg [2:0] flt_slot_r;
    reg [31:0] map_tgt_r;
    reg [31:0] stat_sel_r;
    reg [15:0] hist_r [0:`SMDD_FLT_SLOTS-1];
    reg [31:0] rd_nxt;
    reg [31:0] mon_val;
    reg [31:0] fv_val;
    reg fv_sgn;
    reg fv_hex;
    reg fv_wide;
    reg fv_high;
    reg fv_blank;
    reg fv_dp1;
    reg [24:0] lit_glyph;
    reg lit_on;
    reg conv_busy_r;
    reg [31:0] cap_val_r;
    reg cap_neg_r;
    reg cap_hex_r;
    reg cap_wide_r;
    reg cap_high_r;
    reg cap_blank_r;
    reg cap_dp1_r;
    wire [3:0] key_hit;
    wire [3:0] key_held;
    wire fv_neg;
    wire [31:0] fv_mag;
    wire ctl_wr;
    wire bcd_done;
    wire [39:0] bcd_out;
    wire [24:0] fmt_glyph;
    wire [4:0] fmt_dp;
    integer k;

    function [31:0] smdd_clamp;
        input [31:0] x;
        begin
            if ($signed(x) > $signed(`SMDD_ENC_LIM)) begin
                smdd_clamp = `SMDD_ENC_LIM;
            end else if ($signed(x) < -$signed(`SMDD_ENC_LIM)) begin
                smdd_clamp = -`SMDD_ENC_LIM;
            end else begin
                smdd_clamp = x;
            end
        end
    endfunction

    function [7:0] smdd_byte;
        input [31:0] w;
        input [4:0] idx;
        begin
            smdd_byte = w[idx[1:0]*8 +: 8];
        end
    endfunction

    // Two decimal digit glyphs of a selection code up to 29
    function [9:0] smdd_dec2;
        input [4:0] v;
        begin
            if (v >= 5'h14) begin
                smdd_dec2 = {5'h02, v - 5'h14};
            end else if (v >= 5'h0A) begin
                smdd_dec2 = {5'h01, v - 5'h0A};
            end else begin
                smdd_dec2 = {5'h00, v};
            end
        end
    endfunction

    // Keys are slow pins; press is the synchronised rising edge
    assign key_held = key_s2_r;
    assign key_hit = key_s2_r & ~key_s3_r;
    assign ctl_wr = i_wr && (i_addr == `SMDD_A_DISPCTL);
    assign fv_neg = fv_sgn && !fv_hex && fv_val[31];
    assign fv_mag = fv_neg ? (32'h00000000 - fv_val) : fv_val;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            key_s1_r <= 4'h0;
            key_s2_r <= 4'h0;
            key_s3_r <= 4'h0;
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
            son_s1_r <= 1'b0;
            son_s2_r <= 1'b0;
        end else begin
            key_s1_r <= {i_key_mode, i_key_set, i_key_down, i_key_up};
            key_s2_r <= key_s1_r;
            key_s3_r <= key_s2_r;
            din_s1_r <= i_digital_input;
            din_s2_r <= din_s1_r;
            son_s1_r <= i_servo_on;
            son_s2_r <= son_s1_r;
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_NAME: if (name_cnt_r == NAME_LAST) state_nxt = S_MON;
            S_MON: state_nxt = S_MON;
            S_FPAR: if (key_hit[`SMDD_KSET]) state_nxt = S_FSHOW;
            S_FSHOW: if (key_hit[`SMDD_KMODE]) state_nxt = S_FPAR;
            S_JPAR: if (key_hit[`SMDD_KSET]) state_nxt = S_JSET;
            S_JSET: begin
                if (key_hit[`SMDD_KSET]) begin
                    state_nxt = S_JOG;
                end else if (key_hit[`SMDD_KMODE]) begin
                    state_nxt = S_JPAR;
                end
            end
            S_JOG: if (key_hit[`SMDD_KMODE]) state_nxt = S_JPAR;
            default: state_nxt = S_MON;
        endcase
        if (ctl_wr) begin
            case (i_wdata[`SMDD_CTL_FN])
                `SMDD_FN_MON: state_nxt = S_MON;
                `SMDD_FN_FLT: state_nxt = S_FPAR;
                `SMDD_FN_JOG: state_nxt = S_JPAR;
                default: state_nxt = state_nxt;
            endcase
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= S_NAME;
            name_cnt_r <= 24'h000000;
        end else begin
            state_r <= state_nxt;
            if (state_r == S_NAME) begin
                name_cnt_r <= name_cnt_r + 24'h000001;
            end
        end
    end

    // Software registers; a bus write wins over a key in the same cycle
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mon_sel_r <= 5'h00;
            disp_ctl_r <= 4'h0;
            special_r <= 16'h0000;
            force_en_r <= 1'b0;
            force_val_r <= 5'h00;
            o_jog_speed <= `SMDD_JOG_DEF;
            flt_slot_r <= 3'h0;
            map_tgt_r <= 32'h00000000;
            stat_sel_r <= 32'h00000000;
        end else if (i_wr) begin
            case (i_addr)
                `SMDD_A_MONSEL: if (i_wdata[31:0] <= `SMDD_SEL_MAX)
                    mon_sel_r <= i_wdata[4:0];
                `SMDD_A_DISPCTL: disp_ctl_r <= i_wdata[3:0];
                `SMDD_A_SPECIAL: begin
                    special_r <= i_wdata[15:0];
                    if (i_wdata[15:0] == `SMDD_SPF_FORCE) begin
                        force_en_r <= 1'b1;
                    end else if (i_wdata[15:0] == `SMDD_SPF_NORMAL) begin
                        force_en_r <= 1'b0;
                    end
                end
                `SMDD_A_FORCE: force_val_r <= i_wdata[4:0];
                `SMDD_A_JOGSPD: if (i_wdata[15:0] <= `SMDD_JOG_MAX)
                    o_jog_speed <= i_wdata[15:0];
                `SMDD_A_FLTSLOT: if (i_wdata[31:0] <= `SMDD_SLOT_MAX)
                    flt_slot_r <= i_wdata[2:0];
                `SMDD_A_MAPTGT: map_tgt_r <= i_wdata;
                `SMDD_A_STATSEL: stat_sel_r <= i_wdata;
                default: mon_sel_r <= mon_sel_r;
            endcase
        end else if (state_r == S_MON) begin
            if (key_hit[`SMDD_KUP]) begin
                mon_sel_r <= (mon_sel_r == `SMDD_SEL_MAX) ? 5'h00
                             : mon_sel_r + 5'h01;
            end else if (key_hit[`SMDD_KDN]) begin
                mon_sel_r <= (mon_sel_r == 5'h00) ? `SMDD_SEL_MAX
                             : mon_sel_r - 5'h01;
            end
        end else if (state_r == S_JSET) begin
            if (key_hit[`SMDD_KUP] && o_jog_speed < `SMDD_JOG_MAX) begin
                o_jog_speed <= o_jog_speed + 16'h0001;
            end else if (key_hit[`SMDD_KDN] && o_jog_speed != 16'h0000) begin
                o_jog_speed <= o_jog_speed - 16'h0001;
            end
        end
    end

    // Newest fault lands in slot 0; oldest drops out
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (k = 0; k < `SMDD_FLT_SLOTS; k = k + 1) begin
                hist_r[k] <= 16'h0000;
            end
        end else if (i_fault_evt) begin
            hist_r[0] <= i_fault_code;
            for (k = 1; k < `SMDD_FLT_SLOTS; k = k + 1) begin
                hist_r[k] <= hist_r[k-1];
            end
        end
    end

    // Quantity source toward the drive and its companion selector
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_quant_sel <= 5'h00;
            o_sub_sel <= 8'h00;
        end else begin
            o_quant_sel <= mon_sel_r;
            if (mon_sel_r >= `SMDD_SEL_MAP0 && mon_sel_r <= `SMDD_SEL_MAP3) begin
                o_sub_sel <= smdd_byte(map_tgt_r, mon_sel_r - `SMDD_SEL_MAP0);
            end else if (mon_sel_r >= `SMDD_SEL_STAT0) begin
                o_sub_sel <= smdd_byte(stat_sel_r,
                                       mon_sel_r - `SMDD_SEL_STAT0);
            end else begin
                o_sub_sel <= 8'h00;
            end
        end
    end

    always @* begin
        case (mon_sel_r)
            `SMDD_SEL_RES: mon_val = {i_res2_hz, i_res1_hz};
            `SMDD_SEL_ENC: mon_val = smdd_clamp(i_enc_index_pos);
            default: mon_val = i_quant_data;
        endcase
    end

    always @* begin
        fv_val = 32'h00000000;
        fv_sgn = 1'b0;
        fv_hex = 1'b0;
        fv_wide = 1'b0;
        fv_high = 1'b0;
        fv_blank = 1'b0;
        fv_dp1 = 1'b0;
        case (state_r)
            S_MON: begin
                if (disp_ctl_r[`SMDD_CTL_VIEW] == 2'h0) begin
                    fv_val = mon_val;
                    fv_sgn = 1'b1;
                    fv_wide = 1'b1;
                    fv_hex = disp_ctl_r[`SMDD_CTL_HEX];
                    fv_high = disp_ctl_r[`SMDD_CTL_HIGH];
                    fv_dp1 = (mon_sel_r == `SMDD_SEL_INERTIA) && !fv_high;
                end else begin
                    fv_hex = 1'b1;
                    case (disp_ctl_r[`SMDD_CTL_VIEW])
                        `SMDD_VIEW_FORCE: begin
                            fv_val = {27'h0000000, force_val_r};
                            fv_blank = 1'b1;
                        end
                        `SMDD_VIEW_IN: fv_val = {24'h000000, din_s2_r};
                        `SMDD_VIEW_OUT: fv_val = {27'h0000000, o_dout};
                        default: fv_val = 32'h00000000;
                    endcase
                end
            end
            S_FPAR: fv_val = {29'h00000000, flt_slot_r};
            S_FSHOW: fv_val = {16'h0000, hist_r[flt_slot_r]};
            S_JSET: fv_val = {16'h0000, o_jog_speed};
            default: fv_val = 32'h00000000;
        endcase
    end

    always @* begin
        lit_on = 1'b1;
        lit_glyph = {5{`SMDD_G_BLANK}};
        case (state_r)
            S_NAME: lit_glyph = {`SMDD_G_NAME, `SMDD_G_BLANK, `SMDD_G_BLANK,
                                 smdd_dec2(mon_sel_r)};
            S_JPAR: lit_glyph = {`SMDD_G_J, {4{`SMDD_G_BLANK}}};
            S_JOG: lit_glyph = {`SMDD_G_BLANK, `SMDD_G_BLANK, `SMDD_G_J,
                                `SMDD_G_ZERO, `SMDD_G_G};
            default: lit_on = 1'b0;
        endcase
    end

    // Snapshot the value so sign, digits and hex agree within one frame
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            conv_busy_r <= 1'b0;
            cap_val_r <= 32'h00000000;
            cap_neg_r <= 1'b0;
            cap_hex_r <= 1'b0;
            cap_wide_r <= 1'b0;
            cap_high_r <= 1'b0;
            cap_blank_r <= 1'b0;
            cap_dp1_r <= 1'b0;
        end else if (!conv_busy_r) begin
            conv_busy_r <= 1'b1;
            cap_val_r <= fv_val;
            cap_neg_r <= fv_neg;
            cap_hex_r <= fv_hex;
            cap_wide_r <= fv_wide;
            cap_high_r <= fv_high;
            cap_blank_r <= fv_blank;
            cap_dp1_r <= fv_dp1;
        end else if (bcd_done) begin
            conv_busy_r <= 1'b0;
        end
    end

    smdd_bcd u_bcd (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(~conv_busy_r),
        .i_bin(fv_mag),
        .o_done(bcd_done),
        .o_bcd(bcd_out)
    );

    smdd_fmt u_fmt (
        .i_val(cap_val_r),
        .i_bcd(bcd_out),
        .i_neg(cap_neg_r),
        .i_hex(cap_hex_r),
        .i_wide(cap_wide_r),
        .i_high(cap_high_r),
        .i_blank5(cap_blank_r),
        .i_dp1(cap_dp1_r),
        .o_glyph(fmt_glyph),
        .o_dp(fmt_dp)
    );

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_disp_glyph <= {5{`SMDD_G_BLANK}};
            o_disp_dp <= 5'h00;
        end else if (lit_on) begin
            o_disp_glyph <= lit_glyph;
            o_disp_dp <= 5'h00;
        end else if (bcd_done) begin
            o_disp_glyph <= fmt_glyph;
            o_disp_dp <= fmt_dp;
        end
    end

    // Outputs and jog motion; reset also clears the forcing state
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dout <= 5'h00;
            o_jog_fwd <= 1'b0;
            o_jog_rev <= 1'b0;
        end else begin
            if (force_en_r && !son_s2_r) begin
                o_dout <= force_val_r;
            end else begin
                o_dout <= i_do_normal;
            end
            o_jog_fwd <= (state_r == S_JOG) && son_s2_r &&
                         key_held[`SMDD_KUP] && !key_held[`SMDD_KDN];
            o_jog_rev <= (state_r == S_JOG) && son_s2_r &&
                         key_held[`SMDD_KDN] && !key_held[`SMDD_KUP];
        end
    end

    always @* begin
        case (i_addr)
            `SMDD_A_MONSEL: rd_nxt = {27'h0000000, mon_sel_r};
            `SMDD_A_DISPCTL: rd_nxt = {28'h0000000, disp_ctl_r};
            `SMDD_A_SPECIAL: rd_nxt = {16'h0000, special_r};
            `SMDD_A_FORCE: rd_nxt = {27'h0000000, force_val_r};
            `SMDD_A_INSTAT: rd_nxt = {24'h000000, din_s2_r};
            `SMDD_A_OUTSTAT: rd_nxt = {27'h0000000, o_dout};
            `SMDD_A_JOGSPD: rd_nxt = {16'h0000, o_jog_speed};
            `SMDD_A_FLTSLOT: rd_nxt = {29'h00000000, flt_slot_r};
            `SMDD_A_MAPTGT: rd_nxt = map_tgt_r;
            `SMDD_A_STATSEL: rd_nxt = stat_sel_r;
            `SMDD_A_PANEL: rd_nxt = {24'h000000, force_en_r, state_r};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= i_rd ? rd_nxt : 32'h00000000;
        end
    end
endmodule // smdd_top

// File: logic/smdd_map.vh
// Register map, codes, glyphs and timing of the monitor display block
`ifndef SMDD_MAP_VH
`define SMDD_MAP_VH
`define SMDD_A_MONSEL 4'h0
`define SMDD_A_DISPCTL 4'h1
`define SMDD_A_SPECIAL 4'h2
`define SMDD_A_FORCE 4'h3
`define SMDD_A_INSTAT 4'h4
`define SMDD_A_OUTSTAT 4'h5
`define SMDD_A_JOGSPD 4'h6
`define SMDD_A_FLTSLOT 4'h7
`define SMDD_A_MAPTGT 4'h8
`define SMDD_A_STATSEL 4'h9
`define SMDD_A_PANEL 4'hA
`define SMDD_CTL_HEX 0
`define SMDD_CTL_HIGH 1
`define SMDD_CTL_VIEW 3:2
`define SMDD_CTL_FN 5:4
`define SMDD_FN_MON 2'h1
`define SMDD_FN_FLT 2'h2
`define SMDD_FN_JOG 2'h3
`define SMDD_VIEW_FORCE 2'h1
`define SMDD_VIEW_IN 2'h2
`define SMDD_VIEW_OUT 2'h3
`define SMDD_SEL_MAX 5'h1A
`define SMDD_SEL_INERTIA 5'h0F
`define SMDD_SEL_RES 5'h11
`define SMDD_SEL_ENC 5'h12
`define SMDD_SEL_MAP0 5'h13
`define SMDD_SEL_MAP3 5'h16
`define SMDD_SEL_STAT0 5'h17
`define SMDD_SEL_STAT3 5'h1A
`define SMDD_SPF_FORCE 16'h0196
`define SMDD_SPF_NORMAL 16'h0190
`define SMDD_JOG_DEF 16'h0014
`define SMDD_JOG_MAX 16'h1388
`define SMDD_ENC_LIM 32'h00001388
`define SMDD_FLT_SLOTS 5
`define SMDD_SLOT_MAX 3'h4
`define SMDD_KUP 0
`define SMDD_KDN 1
`define SMDD_KSET 2
`define SMDD_KMODE 3
`define SMDD_G_BLANK 5'h10
`define SMDD_G_HIGH 5'h11
`define SMDD_G_LOW 5'h12
`define SMDD_G_NAME 5'h13
`define SMDD_G_J 5'h14
`define SMDD_G_G 5'h15
`define SMDD_G_ZERO 5'h00
`define SMDD_DP_NEG 5'h18
`define SMDD_DP_LOW 5'h01
`define SMDD_DP_HIGH 5'h02
`define SMDD_BCD_BITS 6'h20
`define SMDD_BCD_DIGITS 10
`define SMDD_NAME_MS 1000
`define SMDD_CLK_KHZ 10000
`endif

// File: logic/smdd_bcd.v
// Serial binary to decimal digit converter, one bit per clock
`include "smdd_map.vh"
module smdd_bcd (
    input wire i_clk,
    input wire i_rst,
    input wire i_start,
    input wire [31:0] i_bin,
    output reg o_done,
    output reg [39:0] o_bcd
);
    reg [31:0] sh_r;
    reg [39:0] acc_r;
    reg [5:0] cnt_r;
    reg busy_r;
    wire [39:0] acc_adj;
    wire [39:0] acc_nxt;

    function [39:0] smdd_adj3;
        input [39:0] b;
        integer k;
        begin
            smdd_adj3 = b;
            for (k = 0; k < `SMDD_BCD_DIGITS; k = k + 1) begin
                if (b[k*4 +: 4] > 4'h4) begin
                    smdd_adj3[k*4 +: 4] = b[k*4 +: 4] + 4'h3;
                end
            end
        end
    endfunction

    assign acc_adj = smdd_adj3(acc_r);
    assign acc_nxt = {acc_adj[38:0], sh_r[31]};

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_r <= 32'h00000000;
            acc_r <= 40'h0000000000;
            cnt_r <= 6'h00;
            busy_r <= 1'b0;
            o_done <= 1'b0;
            o_bcd <= 40'h0000000000;
        end else if (!busy_r) begin
            o_done <= 1'b0;
            if (i_start) begin
                sh_r <= i_bin;
                acc_r <= 40'h0000000000;
                cnt_r <= `SMDD_BCD_BITS;
                busy_r <= 1'b1;
            end
        end else begin
            acc_r <= acc_nxt;
            sh_r <= {sh_r[30:0], 1'b0};
            cnt_r <= cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
                busy_r <= 1'b0;
                o_done <= 1'b1;
                o_bcd <= acc_nxt;
            end
        end
    end
endmodule // smdd_bcd

// File: logic/smdd_fmt.v
// Five digit glyph and decimal point formatter
`include "smdd_map.vh"
module smdd_fmt (
    input wire [31:0] i_val,
    input wire [39:0] i_bcd,
    input wire i_neg,
    input wire i_hex,
    input wire i_wide,
    input wire i_high,
    input wire i_blank5,
    input wire i_dp1,
    output reg [24:0] o_glyph,
    output reg [4:0] o_dp
);
    function [24:0] smdd_dig5;
        input [19:0] n;
        begin
            smdd_dig5 = {1'b0, n[19:16], 1'b0, n[15:12], 1'b0, n[11:8],
                         1'b0, n[7:4], 1'b0, n[3:0]};
        end
    endfunction

    always @* begin
        o_glyph = smdd_dig5(i_bcd[19:0]);
        o_dp = 5'h00;
        if (i_hex) begin
            if (i_wide) begin
                o_glyph = smdd_dig5({4'h0, i_high ? i_val[31:16]
                                                  : i_val[15:0]});
                o_glyph[24:20] = i_high ? `SMDD_G_HIGH : `SMDD_G_LOW;
            end else begin
                o_glyph = smdd_dig5({4'h0, i_val[15:0]});
                if (i_blank5) begin
                    o_glyph[24:20] = `SMDD_G_BLANK;
                end
            end
        end else begin
            if (i_wide && i_high) begin
                o_glyph = smdd_dig5(i_bcd[39:20]);
            end
            if (i_wide) begin
                o_dp = i_high ? `SMDD_DP_HIGH : `SMDD_DP_LOW;
            end
            if (i_dp1) begin
                o_dp = o_dp | `SMDD_DP_HIGH;
            end
            if (i_neg) begin
                o_dp = o_dp | `SMDD_DP_NEG;
            end
        end
    end
endmodule // smdd_fmt

// File: verif/smdd_keypad.sv
// Operator keypad model: keys held as levels
module smdd_keypad (
    input wire i_clk,
    input wire [3:0] i_push,
    output logic [3:0] o_key
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_key = 4'h0;
    // key held level
    // A person lags the clock, so keys move a cycle late
    always @(posedge i_clk) begin
        o_key <= i_push;
    end
endmodule // smdd_keypad

// File: verif/smdd_chk_asserts.sv
// Port checker of the monitor display block
module smdd_chk (
    input wire i_clk,
    input wire i_rst,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_servo_on,
    input wire [4:0] i_do_normal,
    input wire [4:0] o_quant_sel,
    input wire [7:0] o_sub_sel,
    input wire [4:0] o_dout,
    input wire o_jog_fwd,
    input wire o_jog_rev,
    input wire [15:0] o_jog_speed
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    jog_one_way_a: assert property (!(o_jog_fwd && o_jog_rev))
        else $error("jog both ways");
    jog_servo_a: assert property (!i_servo_on [*5] |->
        !(o_jog_fwd || o_jog_rev)) else $error("jog with servo off");
    jog_max_a: assert property (o_jog_speed <= 16'h1388)
        else $error("jog speed too high");
    dout_normal_a: assert property (i_servo_on [*5] |->
        o_dout == $past(i_do_normal)) else $error("forced with servo on");
    sel_max_a: assert property (o_quant_sel <= 5'h1A)
        else $error("selection out of range");
    sel_write_a: assert property (i_wr && i_addr == 4'h0 &&
        i_wdata <= 32'd26 |-> ##2 o_quant_sel == $past(i_wdata[4:0], 2))
        else $error("selection not taken");
    sel_keep_a: assert property (i_wr && i_addr == 4'h0 &&
        i_wdata > 32'd26 |-> ##2 $stable(o_quant_sel))
        else $error("bad selection taken");
    sub_zero_a: assert property (o_quant_sel < 5'h13 |->
        o_sub_sel == 8'h0) else $error("companion byte set");
    cover property (o_jog_fwd);
    cover property (o_dout == 5'h05);
    cover property (o_quant_sel == 5'h11);
endmodule // smdd_chk
bind smdd_top smdd_chk i_smdd_chk (.i_clk, .i_rst, .i_addr, .i_wdata,
    .i_wr, .i_servo_on, .i_do_normal, .o_quant_sel, .o_sub_sel, .o_dout,
    .o_jog_fwd, .o_jog_rev, .o_jog_speed);

// File: verif/smdd_top_bench.sv
// Self-checking bench of the monitor display block
module smdd_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_servo_on = 0;
    logic i_fault_evt = 0, o_jog_fwd, o_jog_rev;
    logic [3:0] i_addr = 4'h0, push = 4'h0, key;
    logic [31:0] i_wdata = 32'h0, i_enc_index_pos = 32'h0, o_rdata;
    logic [15:0] i_res1_hz = 16'h1234, i_res2_hz = 16'hABCD, o_jog_speed;
    logic [7:0] i_digital_input = 8'h0, o_sub_sel;
    logic [4:0] i_do_normal = 5'h0A, o_quant_sel, o_disp_dp, o_dout;
    logic [24:0] o_disp_glyph;
    logic [31:0] i_quant_data = 32'h0;
    logic [15:0] i_fault_code = 16'h0;
    int failures = 0, comparisons = 0;
    always #50 i_clk = ~i_clk;
    smdd_keypad i_smdd_keypad (.i_clk, .i_push(push), .o_key(key));
    smdd_top #(.P_NAME_CYC(20)) i_smdd_top (
        .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_key_up(key[0]), .i_key_down(key[1]), .i_key_set(key[2]),
        .i_key_mode(key[3]), .i_servo_on, .i_digital_input,
        .i_do_normal, .i_fault_evt, .i_fault_code,
        .i_quant_data, .i_res1_hz, .i_res2_hz, .i_enc_index_pos,
        .o_quant_sel, .o_sub_sel, .o_disp_glyph, .o_disp_dp, .o_dout,
        .o_jog_fwd, .o_jog_rev, .o_jog_speed);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 0;
        #1 chk(o_rdata, e);
    endtask
    task hit(input int k);
        push[k] <= 1;
        repeat (10) @(posedge i_clk);
        push[k] <= 0;
        repeat (10) @(posedge i_clk);
    endtask
    // Waits out two conversions so a fresh snapshot is shown
    task see(input logic [4:0] g, input logic [15:0] d, input logic [4:0] p);
        repeat (100) @(posedge i_clk);
        #1 chk({o_disp_glyph, o_disp_dp}, {g, 1'b0, d[15:12], 1'b0,
            d[11:8], 1'b0, d[7:4], 1'b0, d[3:0], p});
    endtask
    task end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (7) @(posedge i_clk);
        #1 chk({o_dout, o_jog_speed}, 32'h14);
        @(posedge i_clk);
        i_rst <= 0;
        wr(4'h0, 32'h5);
        rd(4'h0, 32'h5);
        wr(4'h0, 32'd27);
        rd(4'h0, 32'h5);
        rd(4'hB, 32'h0);
        i_digital_input <= 8'hE1;
        repeat (5) @(posedge i_clk);
        rd(4'h4, 32'hE1);
        wr(4'h8, 32'h44332211);
        wr(4'h9, 32'h88776655);
        wr(4'h0, 32'd20);
        @(posedge i_clk);
        #1 chk(o_sub_sel, 32'h22);
        wr(4'h0, 32'd26);
        @(posedge i_clk);
        #1 chk(o_sub_sel, 32'h88);
        $display("test select done");
        wr(4'h0, 32'd17);
        wr(4'h1, 32'h11);
        see(5'h12, 16'h1234, 5'h00);
        wr(4'h1, 32'h13);
        see(5'h11, 16'hABCD, 5'h00);
        i_enc_index_pos <= -32'sd5;
        wr(4'h0, 32'd18);
        wr(4'h1, 32'h10);
        see(5'h00, 16'h0005, 5'h19);
        i_enc_index_pos <= 32'd9000;
        see(5'h00, 16'h5000, 5'h01);
        i_quant_data <= 32'd130;
        wr(4'h0, 32'd15);
        see(5'h00, 16'h0130, 5'h03);
        $display("test display done");
        wr(4'h2, 32'd406);
        wr(4'h3, 32'h5);
        rd(4'h5, 32'h5);
        i_servo_on <= 1;
        repeat (6) @(posedge i_clk);
        rd(4'h5, 32'hA);
        i_servo_on <= 0;
        wr(4'h3, 32'h2);
        repeat (6) @(posedge i_clk);
        rd(4'h5, 32'h2);
        wr(4'h2, 32'd400);
        rd(4'h5, 32'hA);
        $display("test force done");
        i_servo_on <= 1;
        wr(4'h1, 32'h30);
        hit(2);
        hit(0);
        rd(4'h6, 32'd21);
        hit(2);
        for (int k = 0; k < 2; k++) begin
            push[k] <= 1;
            repeat (8) @(posedge i_clk);
            #1 chk({o_jog_rev, o_jog_fwd}, k + 1);
            push[k] <= 0;
            repeat (8) @(posedge i_clk);
            #1 chk({o_jog_rev, o_jog_fwd}, 0);
        end
        hit(3);
        rd(4'hA, 32'h10);
        $display("test jog done");
        i_fault_code <= 16'd123;
        i_fault_evt <= 1;
        @(posedge i_clk);
        i_fault_code <= 16'd456;
        @(posedge i_clk);
        i_fault_evt <= 0;
        wr(4'h7, 32'h1);
        wr(4'h1, 32'h20);
        hit(2);
        see(5'h00, 16'h0123, 5'h00);
        wr(4'h1, 32'h14);
        see(5'h10, 16'h0002, 5'h00);
        $display("test fault done");
        end_sim;
    end
    initial begin
        #1000000;
        failures++;
        end_sim;
    end
endmodule // smdd_top_bench
